// >>> rtl/mrcal_pkg.sv
// shared constants and types for the mode register command block
`default_nettype none
package mrcal_pkg;
	localparam int CLK_MHZ = 250;
	localparam int TSI_MS = 32;
	// longest interval: rounds down; exact at this rate
	localparam int TSI_CYC = TSI_MS * CLK_MHZ * 1000;
	localparam int CA_W = 10;
	localparam int MR_AW = 8;
	localparam int MR_DW = 8;
	localparam int TEMP_W = 3;
	localparam int LANE_W = 8;
	localparam int LANES = 4;
	localparam int DQ_W = LANE_W * LANES;
	localparam int BEATS = 8;
	localparam int BEAT_W = 3;
	localparam int TMR_W = 32;
	localparam logic [MR_AW-1:0] MR_TEMP = 8'h04;
	localparam logic [MR_AW-1:0] MR_CAL_A = 8'h20;
	localparam logic [MR_AW-1:0] MR_CAL_B = 8'h28;
	localparam logic [MR_AW-1:0] MR_ZQ = 8'h0A;
	localparam logic [MR_AW-1:0] MR_RESET = 8'h3F;
	localparam logic [MR_DW-1:0] OP_ZQ_INIT = 8'hFF;
	localparam logic [MR_DW-1:0] OP_ZQ_LONG = 8'hAB;
	localparam logic [MR_DW-1:0] OP_ZQ_SHORT = 8'h56;
	localparam logic [MR_DW-1:0] OP_ZQ_RST = 8'hC3;
	localparam logic [MR_DW-1:0] OP_RESET_STABLE = 8'hFC;
	localparam logic [MR_DW-1:0] MR_DEFAULT = 8'h00;
	// index i is bit time i
	localparam logic [BEATS-1:0] PAT_A = 8'h55;
	localparam logic [BEATS-1:0] PAT_B = 8'hCC;
	localparam logic [TEMP_W-1:0] TEMP_HOT = 3'h3;
	localparam int CA_CMD_W = 4;
	localparam int CA_RADDR_LSB = 4;
	localparam int CA_FADDR_W = 2;
	localparam int CA_FDATA_LSB = 2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MRW = 2'h1,
		ST_ZQ = 2'h3,
		ST_INIT = 2'h2
	} mrcal_state_type;
	typedef enum logic [1:0] {
		RD_PLAIN = 2'h0,
		RD_PAT_A = 2'h1,
		RD_PAT_B = 2'h2
	} mrcal_rdkind_type;
endpackage
`default_nettype wire

// >>> rtl/mrcal_temp.sv
// temperature status holder refreshed on interval, wake and heating
`default_nettype none
module mrcal_temp
	import mrcal_pkg::*;
#(
	parameter int TSI_CYCLES = TSI_CYC
) (
	input wire logic mclk_i, // clock
	input wire logic reset_n_i, // async reset, low
	input wire logic [TEMP_W-1:0] sensor_code_i, // raw sensor range code
	input wire logic wake_i, // power-down or self-refresh exit
	output logic [TEMP_W-1:0] status_o // held temperature status
);
	logic [TMR_W-1:0] age_ff, nxt_age;
	logic [TEMP_W-1:0] stat_ff, nxt_stat;
	logic upd;

	always_comb begin
		// sensor trips sit 2 degrees below the limit, so a rising code is taken at once
		upd = (age_ff == TMR_W'(TSI_CYCLES - 1)) || wake_i // [RULE2] [RULE3]
			|| (sensor_code_i > stat_ff); // [RULE5]
		nxt_age = upd ? '0 : age_ff + 1'b1;
		nxt_stat = upd ? sensor_code_i : stat_ff;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			age_ff <= '0;
			stat_ff <= '0;
		end else begin
			age_ff <= nxt_age;
			stat_ff <= nxt_stat;
		end
	end

	assign status_o = stat_ff;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	property p_tsi_bound;
		age_ff < TMR_W'(TSI_CYCLES);
	endproperty
	a_tsi_bound: assert property (p_tsi_bound) else $error("status older than interval"); // [RULE2]

	property p_wake_fresh;
		wake_i |=> stat_ff == $past(sensor_code_i);
	endproperty
	a_wake_fresh: assert property (p_wake_fresh) else $error("stale status at wake"); // [RULE3]

	property p_heat_fast;
		(sensor_code_i > stat_ff) |=> stat_ff == $past(sensor_code_i);
	endproperty
	a_heat_fast: assert property (p_heat_fast) else $error("rising code not taken"); // [RULE5]
endmodule
`default_nettype wire

// >>> rtl/mrcal_top.sv
// mode register read/write, reset and impedance calibration interpreter
// Function
// RULE1: controller waits extra delay after power-down exit
// RULE2: temperature status refreshed within update interval
// RULE3: status fresh on power-down or self-refresh exit
// RULE4: temperature field in bits 2..0, code 011
// RULE5: update status 2 degrees before limit
// RULE6: controller polls status fast enough for gradient
// RULE7: pattern reads drive lowest line per lane
// RULE8: pattern A 10101010, pattern B 00110011
// RULE9: other lane lines copy pattern line
// RULE10: write decode: register and data from CA
// RULE11: writes to read-only registers are ignored
// RULE12: controller issues only no-ops during write period
// RULE13: writes only with all banks idle
// RULE14: reads accepted with banks active
// RULE15: reset write restores defaults, enters initialization
// RULE16: controller keeps boot timing after reset
// RULE17: reset accepted with stable operand before training
// RULE18: controller holds CA stable around reset
// RULE19: init and long calibration accurate, reset default
// RULE20: short calibration finishes within its time
// RULE21: calibration only idle, termination disabled
// RULE22: data bus quiet during calibration
// RULE23: shared resistor calibrations must not overlap
// RULE24: read decode: CA3 high, CA2..0 low
// RULE25: eight-beat burst, data in first beat
// RULE26: commands during busy periods are illegal, ignored
`default_nettype none
module mrcal_top
	import mrcal_pkg::*;
#(
	parameter int RL = 8,
	parameter int MRW_CYC = 10,
	parameter int IMPEDANCE_INIT_CALIBRATION_CYC = 250,
	parameter int IMPEDANCE_LONG_CALIBRATION_CYC = 90,
	parameter int IMPEDANCE_SHORT_CALIBRATION_CYC = 23,
	parameter int ZQRST_CYC = 13,
	parameter int INIT_CYC = 250,
	parameter int RCD_CYC = 8,
	parameter int MR_COUNT = 64,
	parameter int TSI_CYCLES = TSI_CYC
) (
	input wire logic mclk_i, // clock
	input wire logic reset_n_i, // async reset, low
	input wire logic cs_n_i, // chip select, low
	input wire logic [CA_W-1:0] ca_rise_i, // CA on rising half
	input wire logic [CA_W-1:0] ca_fall_i, // CA on falling half
	input wire logic banks_active_i, // some bank open
	input wire logic pd_exit_i, // idle power-down exit pulse
	input wire logic sr_exit_i, // self-refresh exit pulse
	input wire logic [TEMP_W-1:0] sensor_code_i, // sensor range code
	output logic [DQ_W-1:0] dq_o, // data out
	output logic dq_oe_o, // data drive enable
	output logic dqs_oe_o, // strobe toggle enable
	output logic [TEMP_W-1:0] temp_status_o, // held temperature status
	output logic mr_write_o, // register stored pulse
	output logic [MR_AW-1:0] mr_addr_o, // stored register number
	output logic [MR_DW-1:0] mr_data_o, // stored value
	output logic zq_busy_o, // calibration running
	output logic zq_accurate_o, // calibrated, not default
	output logic init_busy_o, // auto-initialization running
	output logic array_invalid_o, // array lost pulse
	output logic illegal_cmd_o // refused command pulse
);
	localparam int RD_LAT = RL + 2;
	localparam int ZQS_LAT = IMPEDANCE_SHORT_CALIBRATION_CYC;
	localparam logic [DQ_W-1:0] ONES = '1;
	localparam logic [DQ_W-1:0] ZERO = '0;

	mrcal_state_type state_ff, nxt_state;
	mrcal_rdkind_type kind_ff, nxt_kind;
	logic [TMR_W-1:0] tmr_ff, nxt_tmr;
	logic [TMR_W-1:0] pdw_ff, nxt_pdw;
	logic [TMR_W-1:0] rdw_ff, nxt_rdw;
	logic [BEAT_W-1:0] beat_ff, nxt_beat;
	logic rd_act_ff, nxt_rd_act;
	logic [MR_DW-1:0] rdat_ff, nxt_rdat;
	logic [MR_DW-1:0] zop_ff, nxt_zop;
	logic [DQ_W-1:0] dq_ff, nxt_dq;
	logic dq_oe_ff, nxt_dq_oe;
	logic we_ff, nxt_we;
	logic [MR_AW-1:0] wa_ff, nxt_wa;
	logic [MR_DW-1:0] wd_ff, nxt_wd;
	logic zq_busy_ff, nxt_zq_busy;
	logic zq_acc_ff, nxt_zq_acc;
	logic init_ff, nxt_init;
	logic inval_ff, nxt_inval;
	logic ill_ff, nxt_ill;
	logic [MR_DW-1:0] mr_q [MR_COUNT];
	logic [TEMP_W-1:0] temp_stat;
	logic cmd, is_mrw, is_mrr, busy, rd_go, wr_go, rst_go, zqs_go, clear_all;
	logic [MR_AW-1:0] addr;
	logic [MR_DW-1:0] wdata;
	logic ro_addr;

	mrcal_temp #(
		.TSI_CYCLES(TSI_CYCLES)
	) u_temp (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.sensor_code_i(sensor_code_i),
		.wake_i(pd_exit_i | sr_exit_i),
		.status_o(temp_stat)
	);

	always_comb begin
		cmd = !cs_n_i;
		is_mrw = cmd && (ca_rise_i[CA_CMD_W-1:0] == '0); // [RULE10]
		is_mrr = cmd && (ca_rise_i[CA_CMD_W-2:0] == '0) && ca_rise_i[CA_CMD_W-1]; // [RULE24]
		// top two register bits ride the falling half, so reset with the stable operand
		// repeats its rising half on the falling half
		addr = {ca_fall_i[CA_FADDR_W-1:0], ca_rise_i[CA_W-1:CA_RADDR_LSB]}; // [RULE10]
		wdata = ca_fall_i[CA_W-1:CA_FDATA_LSB];
		ro_addr = (addr == MR_TEMP) || (addr == MR_CAL_A) || (addr == MR_CAL_B);
		busy = (state_ff != ST_IDLE) || rd_act_ff;
	end

	// decode and state
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_zop = zop_ff;
		nxt_zq_acc = zq_acc_ff;
		nxt_ill = 1'b0;
		nxt_we = 1'b0;
		nxt_wa = wa_ff;
		nxt_wd = wd_ff;
		nxt_inval = 1'b0;
		rd_go = 1'b0;
		wr_go = 1'b0;
		rst_go = 1'b0;
		zqs_go = 1'b0;
		clear_all = 1'b0;
		nxt_pdw = pd_exit_i ? TMR_W'(RCD_CYC) : (pdw_ff != '0 ? pdw_ff - 1'b1 : pdw_ff);
		if (state_ff != ST_IDLE) begin
			if (tmr_ff <= TMR_W'(1)) begin
				nxt_state = ST_IDLE;
				if (state_ff == ST_ZQ) begin
					// short calibration only trims, so it keeps the current accuracy
					unique case (zop_ff)
						OP_ZQ_INIT, OP_ZQ_LONG: nxt_zq_acc = 1'b1; // [RULE19]
						OP_ZQ_RST: nxt_zq_acc = 1'b0; // [RULE19]
						default: nxt_zq_acc = zq_acc_ff; // [RULE20]
					endcase
				end
			end else begin
				nxt_tmr = tmr_ff - 1'b1;
			end
		end
		if (is_mrr || is_mrw) begin
			if (busy) begin
				nxt_ill = 1'b1; // [RULE26]
			end else if (is_mrr) begin
				if (pdw_ff != '0) begin
					nxt_ill = 1'b1; // [RULE1]
				end else begin
					rd_go = 1'b1; // [RULE14]
				end
			end else if (banks_active_i) begin
				nxt_ill = 1'b1;
			end else if (addr == MR_RESET) begin
				// any operand, the stable one included, is taken without CA timing
				rst_go = 1'b1; // [RULE17]
				clear_all = 1'b1; // [RULE15]
				nxt_inval = 1'b1;
				nxt_zq_acc = 1'b0;
				nxt_state = ST_INIT;
				nxt_tmr = TMR_W'(INIT_CYC);
			end else if (addr == MR_ZQ && (wdata == OP_ZQ_INIT || wdata == OP_ZQ_LONG
				|| wdata == OP_ZQ_SHORT || wdata == OP_ZQ_RST)) begin
				nxt_zop = wdata;
				nxt_state = ST_ZQ;
				zqs_go = (wdata == OP_ZQ_SHORT);
				unique case (wdata)
					OP_ZQ_INIT: nxt_tmr = TMR_W'(IMPEDANCE_INIT_CALIBRATION_CYC);
					OP_ZQ_LONG: nxt_tmr = TMR_W'(IMPEDANCE_LONG_CALIBRATION_CYC);
					OP_ZQ_SHORT: nxt_tmr = TMR_W'(IMPEDANCE_SHORT_CALIBRATION_CYC); // [RULE20]
					default: nxt_tmr = TMR_W'(ZQRST_CYC);
				endcase
			end else begin
				nxt_state = ST_MRW;
				nxt_tmr = TMR_W'(MRW_CYC);
				if (!ro_addr && addr < MR_AW'(MR_COUNT)) begin
					wr_go = 1'b1; // [RULE11]
					nxt_we = 1'b1;
					nxt_wa = addr;
					nxt_wd = wdata;
				end
			end
		end
		nxt_zq_busy = (nxt_state == ST_ZQ);
		nxt_init = (nxt_state == ST_INIT);
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_IDLE;
			tmr_ff <= '0;
			pdw_ff <= '0;
			zop_ff <= MR_DEFAULT;
			zq_acc_ff <= 1'b0;
			ill_ff <= 1'b0;
			we_ff <= 1'b0;
			wa_ff <= '0;
			wd_ff <= MR_DEFAULT;
			inval_ff <= 1'b0;
			zq_busy_ff <= 1'b0;
			init_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			pdw_ff <= nxt_pdw;
			zop_ff <= nxt_zop;
			zq_acc_ff <= nxt_zq_acc;
			ill_ff <= nxt_ill;
			we_ff <= nxt_we;
			wa_ff <= nxt_wa;
			wd_ff <= nxt_wd;
			inval_ff <= nxt_inval;
			zq_busy_ff <= nxt_zq_busy;
			init_ff <= nxt_init;
		end
	end

	// mode register storage, one entry per register number below MR_COUNT
	genvar gi;
	generate
		for (gi = 0; gi < MR_COUNT; gi++) begin : g_mr
			logic [MR_DW-1:0] mr_ff, nxt_mr;
			always_comb begin
				nxt_mr = mr_ff;
				if (clear_all) begin
					nxt_mr = MR_DEFAULT; // [RULE15]
				end else if (wr_go && addr == MR_AW'(gi)) begin
					nxt_mr = wdata; // [RULE10]
				end
			end
			always_ff @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					mr_ff <= MR_DEFAULT;
				end else begin
					mr_ff <= nxt_mr;
				end
			end
			assign mr_q[gi] = mr_ff;
		end
	endgenerate

	// read burst: latency count, then eight beats
	always_comb begin
		nxt_rd_act = rd_act_ff;
		nxt_rdw = rdw_ff;
		nxt_beat = beat_ff;
		nxt_kind = kind_ff;
		nxt_rdat = rdat_ff;
		nxt_dq = ZERO;
		nxt_dq_oe = 1'b0;
		if (rd_go) begin
			nxt_rd_act = 1'b1;
			nxt_rdw = TMR_W'(RL);
			nxt_beat = '0;
			nxt_kind = (addr == MR_CAL_A) ? RD_PAT_A : (addr == MR_CAL_B) ? RD_PAT_B : RD_PLAIN;
			if (addr == MR_TEMP) begin
				nxt_rdat = {{(MR_DW - TEMP_W){1'b0}}, temp_stat}; // [RULE4]
			end else if (addr < MR_AW'(MR_COUNT)) begin
				nxt_rdat = mr_q[addr[$clog2(MR_COUNT)-1:0]];
			end else begin
				nxt_rdat = MR_DEFAULT;
			end
		end else if (rd_act_ff) begin
			if (rdw_ff != '0) begin
				nxt_rdw = rdw_ff - 1'b1;
			end else begin
				nxt_dq_oe = 1'b1; // [RULE25]
				nxt_beat = beat_ff + 1'b1;
				nxt_rd_act = (beat_ff != BEAT_W'(BEATS - 1));
				unique case (kind_ff)
					// copying the pattern onto every lane line keeps all DQ toggling alike
					RD_PAT_A: nxt_dq = PAT_A[beat_ff] ? ONES : ZERO; // [RULE7] [RULE8] [RULE9]
					RD_PAT_B: nxt_dq = PAT_B[beat_ff] ? ONES : ZERO; // [RULE7] [RULE8] [RULE9]
					default: nxt_dq = (beat_ff == '0) ? DQ_W'(rdat_ff) : ZERO; // [RULE25]
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_act_ff <= 1'b0;
			rdw_ff <= '0;
			beat_ff <= '0;
			kind_ff <= RD_PLAIN;
			rdat_ff <= MR_DEFAULT;
			dq_ff <= ZERO;
			dq_oe_ff <= 1'b0;
		end else begin
			rd_act_ff <= nxt_rd_act;
			rdw_ff <= nxt_rdw;
			beat_ff <= nxt_beat;
			kind_ff <= nxt_kind;
			rdat_ff <= nxt_rdat;
			dq_ff <= nxt_dq;
			dq_oe_ff <= nxt_dq_oe;
		end
	end

	assign dq_o = dq_ff;
	assign dq_oe_o = dq_oe_ff;
	assign dqs_oe_o = dq_oe_ff;
	assign temp_status_o = temp_stat;
	assign mr_write_o = we_ff;
	assign mr_addr_o = wa_ff;
	assign mr_data_o = wd_ff;
	assign zq_busy_o = zq_busy_ff;
	assign zq_accurate_o = zq_acc_ff;
	assign init_busy_o = init_ff;
	assign array_invalid_o = inval_ff;
	assign illegal_cmd_o = ill_ff;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_pat_a;
		dq_o == ONES ##1 dq_o == ZERO ##1 dq_o == ONES ##1 dq_o == ZERO
			##1 dq_o == ONES ##1 dq_o == ZERO ##1 dq_o == ONES ##1 dq_o == ZERO;
	endsequence
	sequence s_pat_b;
		dq_o == ZERO ##1 dq_o == ZERO ##1 dq_o == ONES ##1 dq_o == ONES
			##1 dq_o == ZERO ##1 dq_o == ZERO ##1 dq_o == ONES ##1 dq_o == ONES;
	endsequence

	property p_pat_a;
		rd_go && addr == MR_CAL_A |-> ##RD_LAT s_pat_a;
	endproperty
	a_pat_a: assert property (p_pat_a) else $error("pattern A wrong"); // [RULE7] [RULE8]

	property p_pat_b;
		rd_go && addr == MR_CAL_B |-> ##RD_LAT s_pat_b;
	endproperty
	a_pat_b: assert property (p_pat_b) else $error("pattern B wrong"); // [RULE8] [RULE9]

	property p_plain_read;
		rd_go && addr == MR_TEMP |-> ##RD_LAT
			dq_oe_o && dq_o == DQ_W'($past(temp_status_o, RD_LAT)) ##1 (dq_o == ZERO)[*7];
	endproperty
	a_plain_read: assert property (p_plain_read) else $error("plain read data wrong"); // [RULE25]

	property p_burst_len;
		$rose(dq_oe_o) |-> dq_oe_o[*8] ##1 !dq_oe_o;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst not eight beats"); // [RULE25]

	property p_mrw_store;
		wr_go |=> mr_write_o && mr_addr_o == $past(addr) && mr_data_o == $past(wdata);
	endproperty
	a_mrw_store: assert property (p_mrw_store) else $error("write not stored"); // [RULE10]

	property p_ro_ignore;
		is_mrw && !busy && ro_addr |=> !mr_write_o;
	endproperty
	a_ro_ignore: assert property (p_ro_ignore) else $error("read-only written"); // [RULE11]

	property p_busy_illegal;
		(is_mrw || is_mrr) && busy |=> illegal_cmd_o && !mr_write_o && !array_invalid_o;
	endproperty
	a_busy_illegal: assert property (p_busy_illegal) else $error("busy command not refused"); // [RULE26]

	property p_mrr_active;
		is_mrr && banks_active_i && !busy && pdw_ff == '0 |=> !illegal_cmd_o;
	endproperty
	a_mrr_active: assert property (p_mrr_active) else $error("read refused, banks active"); // [RULE14]

	property p_reset;
		rst_go |=> array_invalid_o && init_busy_o && !zq_accurate_o ##1 !array_invalid_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset command not taken"); // [RULE15] [RULE17]

	property p_zq_short;
		zqs_go |=> zq_busy_o ##ZQS_LAT !zq_busy_o;
	endproperty
	a_zq_short: assert property (p_zq_short) else $error("short calibration overran"); // [RULE20]
endmodule
`default_nettype wire

// >>> dv/mrcal_ctl_model.sv
// controller-side model that places mode register commands on the CA bus
`default_nettype none
module mrcal_ctl_model
	import mrcal_pkg::*;
(
	input wire logic mclk_i, // clock
	output logic cs_n_o, // chip select, low
	output logic [CA_W-1:0] ca_rise_o, // CA rising half
	output logic [CA_W-1:0] ca_fall_o // CA falling half
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n_o = 1'b1;
		ca_rise_o = 10'h155;
		ca_fall_o = 10'h2AA;
	end

	// caller sits just after a falling edge; the command is held over one rising edge
	task automatic send(input logic [7:0] a, input logic [7:0] d, input logic rd);
		logic stable;
		stable = (a == MR_RESET) && !rd;
		ca_rise_o = {a[5:0], rd, 3'h0};
		ca_fall_o = {d, a[7:6]};
		if (stable) begin
			// deselected but already steady, so set-up is met before training
			@(negedge mclk_i);
		end
		cs_n_o = 1'b0;
		@(negedge mclk_i);
		cs_n_o = 1'b1;
		if (stable) begin
			@(negedge mclk_i);
		end
		// released bus shows a changed value, never the old command
		ca_rise_o = ~ca_rise_o;
		ca_fall_o = ~ca_fall_o;
	endtask
endmodule
`default_nettype wire

// >>> dv/mrcal_tb.sv
// self-checking bench for the mode register command block
`default_nettype none
module tb
	import mrcal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TSI = 50;
	localparam int INIT = 20;
	localparam int ZINIT = 20;
	localparam int ZLONG = 15;
	localparam int ZSHORT = 10;
	localparam int ZRST = 5;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cs_n;
	logic [CA_W-1:0] ca_r;
	logic [CA_W-1:0] ca_f;
	logic banks_active_i = 1'b0;
	logic pd_exit_i = 1'b0;
	logic sr_exit_i = 1'b0;
	logic [TEMP_W-1:0] sensor_code_i = 3'h0;
	logic [DQ_W-1:0] dq_o;
	logic dq_oe_o;
	logic dqs_oe_o;
	logic [TEMP_W-1:0] temp_status_o;
	logic mr_write_o;
	logic [MR_AW-1:0] mr_addr_o;
	logic [MR_DW-1:0] mr_data_o;
	logic zq_busy_o;
	logic zq_accurate_o;
	logic init_busy_o;
	logic array_invalid_o;
	logic illegal_cmd_o;
	int mismatches = 0;
	int samples_checked = 0;
	int inval_cnt = 0;

	always #2 mclk_i = ~mclk_i;

	// a pulse can come and go inside a multi-cycle send, so count it at each falling edge
	always @(negedge mclk_i) begin
		if (array_invalid_o === 1'b1) begin
			inval_cnt++;
		end
	end

	mrcal_top #(.TSI_CYCLES(TSI), .INIT_CYC(INIT), .IMPEDANCE_INIT_CALIBRATION_CYC(ZINIT), .IMPEDANCE_LONG_CALIBRATION_CYC(ZLONG),
		.IMPEDANCE_SHORT_CALIBRATION_CYC(ZSHORT), .ZQRST_CYC(ZRST)) dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .ca_rise_i(ca_r),
		.ca_fall_i(ca_f), .banks_active_i(banks_active_i), .pd_exit_i(pd_exit_i),
		.sr_exit_i(sr_exit_i), .sensor_code_i(sensor_code_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.dqs_oe_o(dqs_oe_o), .temp_status_o(temp_status_o), .mr_write_o(mr_write_o),
		.mr_addr_o(mr_addr_o), .mr_data_o(mr_data_o), .zq_busy_o(zq_busy_o),
		.zq_accurate_o(zq_accurate_o), .init_busy_o(init_busy_o),
		.array_invalid_o(array_invalid_o), .illegal_cmd_o(illegal_cmd_o));

	mrcal_ctl_model ctl (.mclk_i(mclk_i), .cs_n_o(cs_n), .ca_rise_o(ca_r), .ca_fall_o(ca_f));

	task automatic step(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// write, then wait out the whole write period so the next command is legal
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic stored);
		ctl.send(a, d, 1'b0);
		chk({31'h0, mr_write_o}, {31'h0, stored});
		if (stored) begin
			chk({24'h0, mr_addr_o}, {24'h0, a});
			chk({24'h0, mr_data_o}, {24'h0, d});
		end
		step(10);
	endtask

	task automatic rd(input logic [7:0] a, input logic pat, input logic [7:0] v);
		logic [31:0] e;
		ctl.send(a, 8'h00, 1'b1);
		step(9);
		for (int b = 0; b < 8; b++) begin
			if (pat) e = {32{v[b]}};
			else e = (b == 0) ? {24'h0, v} : 32'h0;
			chk({30'h0, dq_oe_o, dqs_oe_o}, 32'h3);
			chk(dq_o, e);
			step(1);
		end
		chk({31'h0, dq_oe_o}, 32'h0);
	endtask

	task automatic cal(input logic [7:0] op, input int n, input logic acc);
		int c;
		ctl.send(MR_ZQ, op, 1'b0);
		c = 0;
		// nothing else is issued until the period ends
		while (zq_busy_o === 1'b1 && c < 400) begin
			c++;
			step(1);
		end
		chk(c, n);
		chk({31'h0, zq_accurate_o}, {31'h0, acc});
	endtask

	task automatic t_write_read();
		wr(8'h10, 8'hA5, 1'b1);
		ctl.send(8'h11, 8'h5A, 1'b0);
		step(1);
		ctl.send(8'h12, 8'h3C, 1'b0);
		chk({31'h0, illegal_cmd_o}, 32'h1);
		chk({24'h0, mr_addr_o}, 32'h11);
		step(9);
		wr(MR_TEMP, 8'h77, 1'b0);
		banks_active_i = 1'b1;
		ctl.send(8'h13, 8'h99, 1'b0);
		chk({30'h0, illegal_cmd_o, mr_write_o}, 32'h2);
		step(2);
		rd(8'h10, 1'b0, 8'hA5);
		rd(8'h11, 1'b0, 8'h5A);
		banks_active_i = 1'b0;
		rd(MR_CAL_A, 1'b1, 8'h55);
		rd(MR_CAL_B, 1'b1, 8'hCC);
		$display("test write_read done");
	endtask

	task automatic t_cal_reset();
		int c;
		cal(OP_ZQ_RST, ZRST, 1'b0);
		cal(OP_ZQ_INIT, ZINIT, 1'b1);
		cal(OP_ZQ_SHORT, ZSHORT, 1'b1);
		cal(OP_ZQ_RST, ZRST, 1'b0);
		cal(OP_ZQ_LONG, ZLONG, 1'b1);
		c = inval_cnt;
		ctl.send(MR_RESET, 8'hFC, 1'b0);
		chk(inval_cnt - c, 32'h1);
		chk({30'h0, init_busy_o, zq_accurate_o}, 32'h2);
		// one busy cycle already passed inside the trailing hold of the reset command
		c = 1;
		while (init_busy_o === 1'b1 && c < 400) begin
			c++;
			step(1);
		end
		chk(c, INIT);
		rd(8'h10, 1'b0, 8'h00);
		$display("test cal_reset done");
	endtask

	task automatic t_temp();
		int n;
		sensor_code_i = 3'h3;
		step(2);
		chk({29'h0, temp_status_o}, 32'h3);
		rd(MR_TEMP, 1'b0, 8'h03);
		sensor_code_i = 3'h1;
		n = 0;
		while (temp_status_o !== 3'h1 && n < TSI + 4) begin
			n++;
			step(1);
		end
		chk({29'h0, temp_status_o}, 32'h1);
		chk(32'(n <= TSI + 2), 32'h1);
		sensor_code_i = 3'h0;
		pd_exit_i = 1'b1;
		step(1);
		pd_exit_i = 1'b0;
		step(2);
		chk({29'h0, temp_status_o}, 32'h0);
		ctl.send(MR_TEMP, 8'h00, 1'b1);
		chk({31'h0, illegal_cmd_o}, 32'h1);
		// the next read lands on the first edge after the wait has run out
		step(5);
		rd(MR_TEMP, 1'b0, 8'h00);
		sensor_code_i = 3'h2;
		step(2);
		sensor_code_i = 3'h1;
		sr_exit_i = 1'b1;
		step(1);
		sr_exit_i = 1'b0;
		step(2);
		chk({29'h0, temp_status_o}, 32'h1);
		$display("test temp done");
	endtask

	initial begin
		// generous bound: the whole sequence needs well under a thousand cycles
		#100000;
		mismatches++;
		summarize();
	end

	initial begin
		step(8);
		reset_n_i = 1'b1;
		step(1);
		t_write_read();
		t_cal_reset();
		t_temp();
		summarize();
	end
endmodule
`default_nettype wire
